// ---- verilog/memory_ctl_pkg.sv ----
package memory_ctl_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [11:0] OFS_PAGE      = 12'h034;
  localparam logic [11:0] OFS_WORDCOUNT = 12'h038;
  localparam logic [11:0] OFS_THRESHOLD = 12'h03c;
  localparam logic [11:0] OFS_SCAN_LIM  = 12'h040;
  localparam logic [11:0] OFS_SCAN_CNT  = 12'h044;
  localparam logic [11:0] OFS_LAST_BINS = 12'h048;
  localparam logic [11:0] OFS_ACQ_MODE  = 12'h100;

  // ------------------------------------------------------------------
  // Field positions, widths and reset values
  // ------------------------------------------------------------------
  localparam int          PAGE_W        = 6;
  localparam int          SIZE_BIT      = 8;
  localparam int          COUNT_W       = 27;
  localparam int          WIN_W         = 21;
  localparam logic [31:0] MODE_MASK     = 32'h70bf737d;
  localparam logic [31:0] MODE_RESET    = 32'h00000000;
  localparam logic [31:0] SCAN_LIM_RST  = 32'h00000000;
  localparam logic [5:0]  PAGE_RESET    = 6'h00;
  localparam logic [2:0]  OP_COUNTING   = 3'h0;
  localparam logic [2:0]  OP_MCS        = 3'h2;
  localparam logic [2:0]  OP_WRITE_TEST = 3'h7;
  localparam int          MB64_WORDS    = 16777216;
  localparam int          MB512_WORDS   = 134217728;
  localparam int          MARGIN_WORDS  = 512;
  localparam logic [27:0] LIMIT_64      = 28'(MB64_WORDS - MARGIN_WORDS);
  localparam logic [27:0] LIMIT_512     = 28'(MB512_WORDS - MARGIN_WORDS);
  localparam logic [1:0]  PIPE_EVENTS   = 2'h2;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic               rd;
    logic               wr;
    logic               block;
    logic [WIN_W+1:0]   byte_ofs;
  } mem_req_t;

  typedef struct packed {
    logic [2:0] op_mode;
    logic       out_invert;
    logic [1:0] out_mode;
    logic       in_invert;
    logic [2:0] in_mode;
    logic       scan_origin;
    logic       add_mode;
    logic       ram_mode;
    logic [1:0] arm_source;
    logic [2:0] next_event_source;
    logic [1:0] data_format;
    logic       non_clearing;
  } acq_mode_t;

endpackage

// ---- verilog/memory_ctl.sv ----
`timescale 1ns/1ps
module memory_ctl (
  input  wire logic                      core_clk,
  input  wire logic                      reset_n,
  input  wire memory_ctl_pkg::reg_req_t  reg_req,
  output logic [31:0]                    reg_rdata,
  output logic                           reg_rvalid,
  input  wire memory_ctl_pkg::mem_req_t  mem_req,
  input  wire logic                      key_reset,
  input  wire logic                      key_fifo_reset,
  input  wire logic                      key_scan_start,
  input  wire logic                      histogram_scan_stop_command,
  input  wire logic                      ext_scan_start,
  input  wire logic                      strip_512mb,
  input  wire logic                      next_event_in,
  input  wire logic                      acq_wr,
  input  wire logic                      acq_event_done,
  input  wire logic [31:0]               acq_count,
  output logic                           sdram_wr_en,
  output logic [26:0]                    sdram_wr_addr,
  output logic                           sdram_rd_en,
  output logic [26:0]                    sdram_rd_addr,
  output logic                           next_event_pulse,
  output logic                           scan_start_pulse,
  output logic                           almost_full_irq,
  output logic                           threshold_irq,
  output logic                           random_access,
  output memory_ctl_pkg::acq_mode_t      acq_mode_fields
);
  import memory_ctl_pkg::*;

  typedef struct packed {
    logic [PAGE_W-1:0]  page;
    logic [31:0]        mode;
    logic [COUNT_W-1:0] threshold;
    logic [31:0]        scan_limit;
    logic [COUNT_W-1:0] word_count;
    logic [COUNT_W-1:0] wr_ptr;
    logic [COUNT_W-1:0] rd_ptr;
    logic               almost_full;
    logic [1:0]         pipe_events;
    logic [31:0]        scan_count;
    logic [31:0]        last_bins;
    logic               scan_stopped;
    logic [31:0]        rdata;
    logic               rvalid;
    logic               size_s1;
    logic               size_s2;
    logic               ext_s1;
    logic               ext_s2;
    logic               ext_d;
    logic               wr_en;
    logic [26:0]        wr_addr;
    logic               rd_en;
    logic [26:0]        rd_addr;
    logic               nev_pulse;
    logic               scan_pulse;
    logic               thr_irq;
  } state_t;

  state_t     st;
  state_t     next_st;
  acq_mode_t  mode_f;
  logic       fifo_mode;
  logic       hist_mode;
  logic [27:0] af_limit;
  logic       write_req;
  logic       write_ok;
  logic       read_req;
  logic       nev_ok;
  logic       start_req;
  logic       start_ok;
  logic       mem_clear;
  logic [COUNT_W-1:0] count_after;

  // ------------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------------
  always_comb begin
    mode_f.op_mode           = st.mode[30:28];
    mode_f.out_invert        = st.mode[23];
    mode_f.out_mode          = st.mode[21:20];
    mode_f.in_invert         = st.mode[19];
    mode_f.in_mode           = st.mode[18:16];
    mode_f.scan_origin       = st.mode[14];
    mode_f.add_mode          = st.mode[13];
    mode_f.ram_mode          = st.mode[12];
    mode_f.arm_source        = st.mode[9:8];
    mode_f.next_event_source = st.mode[6:4];
    mode_f.data_format       = st.mode[3:2];
    mode_f.non_clearing      = st.mode[0];
  end

  assign fifo_mode = !(mode_f.add_mode || mode_f.ram_mode);
  assign hist_mode = mode_f.add_mode && (mode_f.op_mode == OP_MCS);
  assign af_limit  = st.size_s2 ? LIMIT_512 : LIMIT_64;
  assign mem_clear = key_reset || key_fifo_reset;

  // ------------------------------------------------------------------
  // Memory write and read qualification
  // ------------------------------------------------------------------
  always_comb begin
    write_req = 1'b0;
    unique case (mode_f.op_mode)
      OP_MCS:        write_req = acq_wr;
      OP_WRITE_TEST: write_req = mem_req.wr;
      default:       write_req = 1'b0;
    endcase
    // Data of events already past the gate may still land in memory.
    write_ok  = write_req && (!st.almost_full || st.pipe_events != 2'h0);
    read_req  = mem_req.rd;
    nev_ok    = next_event_in && !st.almost_full;
    start_req = mode_f.scan_origin ? (st.ext_s2 && !st.ext_d) : key_scan_start;
    start_ok  = start_req && hist_mode && !st.scan_stopped
                && (st.scan_limit == 32'h0 || st.scan_count < st.scan_limit);
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.size_s1    = strip_512mb;
    next_st.size_s2    = st.size_s1;
    next_st.ext_s1     = ext_scan_start;
    next_st.ext_s2     = st.ext_s1;
    next_st.ext_d      = st.ext_s2;
    next_st.rvalid     = reg_req.rd;
    next_st.nev_pulse  = nev_ok;
    next_st.scan_pulse = start_ok;
    next_st.wr_en      = write_ok;
    next_st.rd_en      = read_req;

    // Register reads.
    next_st.rdata = 32'h0;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        OFS_PAGE: begin
          next_st.rdata[PAGE_W-1:0] = st.page;
          next_st.rdata[SIZE_BIT]   = st.size_s2;
        end
        OFS_WORDCOUNT: next_st.rdata[COUNT_W-1:0] = st.word_count;
        OFS_THRESHOLD: next_st.rdata[COUNT_W-1:0] = st.threshold;
        OFS_SCAN_LIM:  next_st.rdata = st.scan_limit;
        OFS_SCAN_CNT:  next_st.rdata = st.scan_count;
        OFS_LAST_BINS: next_st.rdata = st.last_bins;
        OFS_ACQ_MODE:  next_st.rdata = st.mode;
        default:       next_st.rdata = 32'h0;
      endcase
    end

    // Register writes.
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        OFS_PAGE:      next_st.page = reg_req.wdata[PAGE_W-1:0];
        OFS_THRESHOLD: next_st.threshold = reg_req.wdata[COUNT_W-1:0];
        OFS_SCAN_LIM:  next_st.scan_limit = reg_req.wdata;
        OFS_ACQ_MODE:  next_st.mode = reg_req.wdata & MODE_MASK;
        default:       next_st.mode = st.mode;
      endcase
    end

    // Read address: internal pointer in FIFO mode, page plus bus address otherwise.
    if (fifo_mode) begin
      next_st.rd_addr = st.rd_ptr;
    end else begin
      next_st.rd_addr = {st.page, mem_req.byte_ofs[WIN_W+1:2]};
    end
    if (read_req) begin
      if (fifo_mode) begin
        next_st.rd_ptr = st.rd_ptr + 27'h1;
      end
      // A block read outside FIFO mode leaving the last word of a window moves to the next window.
      if (mem_req.block && !fifo_mode && (&mem_req.byte_ofs[WIN_W+1:2])) begin
        next_st.page = st.page + 6'h1;
      end
    end

    // Writes advance the write pointer in every memory mode.
    next_st.wr_addr = st.wr_ptr;
    if (write_ok) begin
      next_st.wr_ptr = st.wr_ptr + 27'h1;
    end

    // Fill level.
    count_after = st.word_count;
    if (write_ok && !read_req) begin
      count_after = st.word_count + 27'h1;
    end else if (read_req && !write_ok && st.word_count != 27'h0) begin
      count_after = st.word_count - 27'h1;
    end
    next_st.word_count = count_after;
    next_st.thr_irq    = count_after > st.threshold;

    // Events in flight that may still store data after almost-full.
    if (nev_ok && !acq_event_done && st.pipe_events != PIPE_EVENTS) begin
      next_st.pipe_events = st.pipe_events + 2'h1;
    end else if (acq_event_done && !nev_ok && st.pipe_events != 2'h0) begin
      next_st.pipe_events = st.pipe_events - 2'h1;
    end

    // Almost-full stays set until the memory key reset.
    if (fifo_mode && {1'b0, count_after} >= af_limit) begin
      next_st.almost_full = 1'b1;
    end

    // Histogram scan bookkeeping.
    if (start_ok) begin
      next_st.scan_count = st.scan_count + 32'h1;
      next_st.last_bins  = acq_count;
    end
    if (histogram_scan_stop_command) begin
      next_st.scan_stopped = 1'b1;
    end

    // Key resets.
    if (mem_clear) begin
      next_st.word_count  = '0;
      next_st.wr_ptr      = '0;
      next_st.rd_ptr      = '0;
      next_st.almost_full = 1'b0;
      next_st.pipe_events = 2'h0;
      next_st.thr_irq     = 1'b0;
    end
    if (key_reset) begin
      next_st.page         = PAGE_RESET;
      next_st.mode         = MODE_RESET;
      next_st.scan_limit   = SCAN_LIM_RST;
      next_st.scan_count   = 32'h0;
      next_st.last_bins    = 32'h0;
      next_st.scan_stopped = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st            <= '0;
      st.page       <= PAGE_RESET;
      st.mode       <= MODE_RESET;
      st.scan_limit <= SCAN_LIM_RST;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign reg_rdata        = st.rdata;
  assign reg_rvalid       = st.rvalid;
  assign sdram_wr_en      = st.wr_en;
  assign sdram_wr_addr    = st.wr_addr;
  assign sdram_rd_en      = st.rd_en;
  assign sdram_rd_addr    = st.rd_addr;
  assign next_event_pulse = st.nev_pulse;
  assign scan_start_pulse = st.scan_pulse;
  assign almost_full_irq  = st.almost_full;
  assign threshold_irq    = st.thr_irq;
  assign random_access    = !fifo_mode;
  assign acq_mode_fields  = mode_f;

endmodule

// ---- sim/memory_ctl_props.sv ----
`timescale 1ns/1ps
module memory_ctl_props
  import memory_ctl_pkg::*;
(
  input wire logic                      core_clk,
  input wire logic                      reset_n,
  input wire memory_ctl_pkg::reg_req_t  reg_req,
  input wire logic [31:0]               reg_rdata,
  input wire logic                      reg_rvalid,
  input wire memory_ctl_pkg::mem_req_t  mem_req,
  input wire logic                      acq_wr,
  input wire logic                      next_event_in,
  input wire logic                      next_event_pulse,
  input wire logic                      sdram_wr_en,
  input wire logic                      sdram_rd_en,
  input wire logic                      random_access,
  input wire memory_ctl_pkg::acq_mode_t acq_mode_fields
);
  // ----------------------------------------------------------------
  // Port relations.
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  read_answer_a:
    assert property (reg_req.rd |=> reg_rvalid) else $error("read strobe not answered");
  page_bits_a:
    assert property (reg_rvalid && $past(reg_req.addr) == OFS_PAGE |->
      reg_rdata[31:9] == 23'h0 && reg_rdata[7:6] == 2'h0) else $error("page pad bits set");
  count_bits_a:
    assert property (reg_rvalid && $past(reg_req.addr) == OFS_WORDCOUNT |->
      reg_rdata[31:27] == 5'h0) else $error("word count pad bits set");
  mode_bits_a:
    assert property (reg_rvalid && $past(reg_req.addr) == OFS_ACQ_MODE |->
      (reg_rdata & ~MODE_MASK) == 32'h0) else $error("mode reserved bits set");
  ram_select_a:
    assert property (random_access == (acq_mode_fields.ram_mode | acq_mode_fields.add_mode))
      else $error("memory mode select wrong");
  bus_read_a:
    assert property (mem_req.rd |=> sdram_rd_en) else $error("bus read not issued");
  write_cause_a:
    assert property (sdram_wr_en |-> $past(acq_wr || mem_req.wr))
      else $error("memory write without request");
  event_pass_a:
    assert property (next_event_pulse |-> $past(next_event_in))
      else $error("next event without request");
endmodule

// ---- sim/vme_host.sv ----
`timescale 1ns/1ps
module vme_host
  import memory_ctl_pkg::*;
(
  input  wire logic                core_clk,
  output memory_ctl_pkg::reg_req_t reg_req,
  output memory_ctl_pkg::mem_req_t mem_req
);
  // ----------------------------------------------------------------
  // Bus master cycles; released lines carry inverted values, except in mwr, which releases them to zero.
  // ----------------------------------------------------------------
  initial begin
    reg_req = '0;
    mem_req = '0;
  end
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    tick;
    reg_req = '{1'b1, 1'b0, a, d};
    tick;
    reg_req = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    tick;
    reg_req = '{1'b0, 1'b1, a, 32'h0};
    tick;
    reg_req = '{1'b0, 1'b0, ~a, 32'hffffffff};
    d = testbench.reg_rdata;
  endtask
  task automatic mrd(input logic b, input logic [22:0] o);
    tick;
    mem_req = '{1'b1, 1'b0, b, o};
    tick;
    mem_req = '{1'b0, 1'b0, 1'b0, ~o};
  endtask
  task automatic mwr;
    tick;
    mem_req = '{1'b0, 1'b1, 1'b0, 23'h0};
    tick;
    mem_req = '0;
  endtask
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import memory_ctl_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus, reference model and checks.
  // ----------------------------------------------------------------
  logic core_clk = 1'b0, reset_n = 1'b0, strip_512mb = 1'b1;
  logic key_reset = 1'b0, key_fifo_reset = 1'b0, key_scan_start = 1'b0;
  logic next_event_in = 1'b0, acq_wr = 1'b0, scan_stop = 1'b0;
  logic reg_rvalid, sdram_wr_en, sdram_rd_en, next_event_pulse, scan_start_pulse;
  logic almost_full_irq, threshold_irq, random_access;
  logic [26:0] sdram_wr_addr, sdram_rd_addr;
  logic [31:0] acq_count = 32'h0, reg_rdata, d, m, last;
  logic [11:0] ofs [8] = '{OFS_PAGE, OFS_WORDCOUNT, OFS_THRESHOLD, OFS_SCAN_LIM,
                           OFS_SCAN_CNT, OFS_LAST_BINS, OFS_ACQ_MODE, 12'h050};
  logic [2:0] ops [3] = '{OP_COUNTING, OP_MCS, OP_WRITE_TEST};
  reg_req_t reg_req;
  mem_req_t mem_req;
  acq_mode_t acq_mode_fields;
  int mismatches = 0, checked = 0, wc = 0, wp = 0, rp = 0, pg, n, thr;
  always #5 core_clk = ~core_clk;
  memory_ctl memory_ctl_inst (.core_clk(core_clk), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .mem_req(mem_req),
    .key_reset(key_reset), .key_fifo_reset(key_fifo_reset), .key_scan_start(key_scan_start),
    .histogram_scan_stop_command(scan_stop), .ext_scan_start(1'b0), .strip_512mb(strip_512mb),
    .next_event_in(next_event_in), .acq_wr(acq_wr), .acq_event_done(1'b0),
    .acq_count(acq_count), .sdram_wr_en(sdram_wr_en), .sdram_wr_addr(sdram_wr_addr),
    .sdram_rd_en(sdram_rd_en), .sdram_rd_addr(sdram_rd_addr),
    .next_event_pulse(next_event_pulse), .scan_start_pulse(scan_start_pulse),
    .almost_full_irq(almost_full_irq), .threshold_irq(threshold_irq),
    .random_access(random_access), .acq_mode_fields(acq_mode_fields));
  vme_host host_inst (.core_clk(core_clk), .reg_req(reg_req), .mem_req(mem_req));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic pulse(ref logic s);
    host_inst.tick;
    s = 1'b1;
    host_inst.tick;
    s = 1'b0;
  endtask
  task automatic acq(input int k);
    repeat (k) begin
      host_inst.tick;
      acq_wr = 1'b1;
      next_event_in = 1'b1;
      host_inst.tick;
      acq_wr = 1'b0;
      next_event_in = 1'b0;
      chk("wr_en", {31'h0, sdram_wr_en & next_event_pulse}, 32'h1);
      chk("wr_addr", {5'h0, sdram_wr_addr}, 32'(wp));
      wp++;
      wc++;
    end
  endtask
  task automatic fifo_rd(input int k);
    repeat (k) begin
      host_inst.mrd(1'b0, 23'h0);
      chk("rd_addr", {5'h0, sdram_rd_addr}, 32'(rp));
      chk("rd_en", {31'h0, sdram_rd_en}, 32'h1);
      rp++;
      wc--;
    end
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    host_inst.rd(a, d);
    chk(nm, d, e);
  endtask
  initial begin
    m = $urandom(87);
    repeat (2) @(posedge core_clk);
    #1 reset_n = 1'b1;
    repeat (2) host_inst.tick;
    foreach (ofs[i]) rdchk("reset", ofs[i], (i == 0) ? 32'h100 : 32'h0);
    foreach (ops[i]) begin
      m = $urandom();
      m[30:28] = ops[i];
      host_inst.wr(OFS_ACQ_MODE, m);
      rdchk("mode", OFS_ACQ_MODE, m & MODE_MASK);
      chk("fields", 32'(acq_mode_fields), {11'h0, m[30:28], m[23], m[21:16], m[14:12],
        m[9:8], m[6:2], m[0]});
      chk("ram", {31'h0, random_access}, {31'h0, m[12] | m[13]});
    end
    m = $urandom();
    host_inst.wr(OFS_PAGE, m);
    rdchk("page", OFS_PAGE, {23'h0, 3'h4, m[5:0]});
    strip_512mb = 1'b0;
    repeat (2) host_inst.tick;
    rdchk("strap", OFS_PAGE, {26'h0, m[5:0]});
    host_inst.wr(OFS_WORDCOUNT, 32'hffffffff);
    host_inst.wr(OFS_ACQ_MODE, 32'h20000000);
    n = 3 + ($urandom() % 6);
    thr = n - 2;
    host_inst.wr(OFS_THRESHOLD, 32'hf8000000 | thr);
    rdchk("threshold", OFS_THRESHOLD, 32'(thr));
    acq(n);
    rdchk("count", OFS_WORDCOUNT, 32'(wc));
    chk("thr_irq", {31'h0, threshold_irq}, 32'h1);
    fifo_rd(3);
    rdchk("count", OFS_WORDCOUNT, 32'(wc));
    chk("thr_irq", {31'h0, threshold_irq | almost_full_irq}, 32'h0);
    pulse(key_fifo_reset);
    wc = 0;
    wp = 0;
    rp = 0;
    acq(1);
    fifo_rd(1);
    rdchk("count", OFS_WORDCOUNT, 32'h0);
    host_inst.wr(OFS_ACQ_MODE, 32'h20001000);
    pg = $urandom() % 64;
    host_inst.wr(OFS_PAGE, 32'(pg));
    acq(2);
    rdchk("page", OFS_PAGE, 32'(pg));
    m = $urandom();
    host_inst.mrd(1'b0, m[22:0]);
    chk("ram_addr", {5'h0, sdram_rd_addr}, {5'h0, 6'(pg), m[22:2]});
    host_inst.mrd(1'b0, 23'h7ffffc);
    rdchk("page", OFS_PAGE, 32'(pg));
    host_inst.mrd(1'b1, 23'h7ffffc);
    rdchk("page", OFS_PAGE, 32'((pg + 1) % 64));
    rdchk("count", OFS_WORDCOUNT, 32'h0);
    host_inst.wr(OFS_ACQ_MODE, 32'h70000000);
    repeat (2) host_inst.mwr;
    rdchk("count", OFS_WORDCOUNT, 32'h2);
    host_inst.wr(OFS_SCAN_LIM, 32'h2);
    host_inst.wr(OFS_ACQ_MODE, 32'h20002000);
    for (int i = 0; i < 3; i++) begin
      acq_count = $urandom();
      if (i < 2) last = acq_count;
      pulse(key_scan_start);
      chk("scan_pulse", {31'h0, scan_start_pulse}, 32'(i < 2));
    end
    rdchk("scan_lim", OFS_SCAN_LIM, 32'h2);
    rdchk("scan_cnt", OFS_SCAN_CNT, 32'h2);
    rdchk("last_bins", OFS_LAST_BINS, last);
    host_inst.wr(OFS_SCAN_LIM, 32'h0);
    pulse(scan_stop);
    pulse(key_scan_start);
    rdchk("scan_stop", OFS_SCAN_CNT, 32'h2);
    pulse(key_reset);
    rdchk("scan_cnt", OFS_SCAN_CNT, 32'h0);
    rdchk("count", OFS_WORDCOUNT, 32'h0);
    results;
  end
  initial begin
    #100000;
    mismatches++;
    results;
  end
endmodule
bind memory_ctl memory_ctl_props memory_ctl_props_inst (.core_clk(core_clk),
  .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .mem_req(mem_req), .acq_wr(acq_wr), .next_event_in(next_event_in),
  .next_event_pulse(next_event_pulse), .sdram_wr_en(sdram_wr_en), .sdram_rd_en(sdram_rd_en),
  .random_access(random_access), .acq_mode_fields(acq_mode_fields));
